// [pmbus_limit_regs.vh]
// Command codes, reset values, field positions and limits of the input limit and power-good set.
`ifndef PMBUS_LIMIT_REGS_VH
`define PMBUS_LIMIT_REGS_VH

`define CMD_OV_REACTION 8'h56
`define CMD_UV_WARN 8'h58
`define CMD_OC_WARN 8'h5D
`define CMD_PG_ASSERT 8'h5E
`define CMD_PG_NEGATE 8'h5F
`define CMD_TURN_ON_DELAY_TIME 8'h60

`define RST_OV_REACTION 8'hB8
`define RST_UV_WARN 16'hF812
`define RST_OC_WARN 16'hF80A
`define RST_PG_ASSERT 16'h0114
`define RST_PG_NEGATE 16'h0105
`define RST_TURN_ON_DELAY_TIME 16'h0000

`define OV_ACTION_MSB 7
`define OV_ACTION_LSB 6
`define OV_RETRY_MSB 5
`define OV_RETRY_LSB 3
`define OV_DELAY_MSB 2
`define OV_DELAY_LSB 0
`define OV_ACT_IGNORE 2'h0
`define OV_ACT_HOLD 2'h3

`define L11_EXP_MSB 15
`define L11_EXP_LSB 11
`define L11_MAN_MSB 10
`define L11_MAN_LSB 0

`define EXP_HALF 5'h1F
`define EXP_UNIT 5'h00
`define UV_MAN_MIN 11'h002
`define UV_MAN_MAX 11'h0A0
`define OC_MAN_MIN 11'h000
`define OC_MAN_MAX 11'h0FE
`define TON_MAN_MIN 11'h000
`define TON_MAN_MAX 11'h07F
`define PG_MIN 16'h007B
`define PG_MAX 16'h1C00

`define CLK_FREQ_HZ 50000000
`define MS_PER_S 1000

`endif

// [linear11_check.v]
// Range and resolution check of one fixed-exponent LINEAR11 word.
`timescale 1ns/1ns
`include "pmbus_limit_regs.vh"
module linear11_check #(
    parameter [4:0] EXP_FIXED = 5'h00,
    parameter [10:0] MAN_MIN = 11'h000,
    parameter [10:0] MAN_MAX = 11'h07F
) (
    input wire [15:0] word, // Word offered by the host
    output wire ok // High when the word may be stored
);
    wire [4:0] exp_field;
    wire signed [10:0] man_field;
    wire exp_ok;
    wire range_ok;

    assign exp_field = word[`L11_EXP_MSB:`L11_EXP_LSB];
    assign man_field = word[`L11_MAN_MSB:`L11_MAN_LSB];
    // Any other exponent cannot hit the fixed step size.
    assign exp_ok = (exp_field == EXP_FIXED);
    assign range_ok = (man_field >= $signed(MAN_MIN)) && (man_field <= $signed(MAN_MAX));
    assign ok = exp_ok && range_ok;
endmodule // linear11_check

// [pmbus_input_limit_pgood_regs.v]
// Input limit, power-good and turn-on delay command registers with their output control.
//
// What this block does
// - Read-write byte at 56h: action bits 7:6, retry 5:3, delay 2:0.
// - The overvoltage reaction byte resets to B8h.
// - Default B8h: output off on fault, no restart, stays off until cleared.
// - Action 00: keep regulating, overvoltage ignored for output control.
// - Action 11 with retry and delay zero: off, no restart, until cleared.
// - Action 11 otherwise: off while fault lasts, back on when it goes.
// - Limit words: 11-bit signed mantissa, 5-bit signed exponent, two bytes.
// - Undervoltage warning at 58h, exponent fixed at minus one.
// - Undervoltage warning accepts 1 V to 80 V in 0.5 V, resets F812h.
// - Out-of-range or wrong-step writes are dropped and reported.
// - Overcurrent warning at 5Dh, exponent minus one, 0 A to 127 A.
// - Overcurrent warning resets to F80Ah.
// - Power-good assert level at 5Eh, unsigned, resets 0114h.
// - Power-good levels span 0.24 V to 14 V in 1.953 mV steps.
// - Power-good negate level at 5Fh, resets 0105h, drops power good.
// - Turn-on delay at 60h, exponent zero, milliseconds from start to rise.
// - Turn-on delay accepts 0 ms to 127 ms, resets to zero.
`timescale 1ns/1ns
`include "pmbus_limit_regs.vh"
module pmbus_input_limit_pgood_regs #(
    parameter CYCLES_PER_MS = `CLK_FREQ_HZ / `MS_PER_S
) (
    input wire sys_clk, // System clock, 50 MHz
    input wire rst, // Synchronous reset, active high
    input wire cmd_valid, // One-cycle command request
    input wire cmd_write, // High for write, low for read
    input wire [7:0] cmd_code, // Command code
    input wire [15:0] cmd_wdata, // Write data, low byte first on the wire
    output reg rsp_valid, // One-cycle answer to a command
    output reg rsp_reject, // With rsp_valid: command was refused
    output reg [15:0] rsp_rdata, // Read data, valid with rsp_valid
    output reg cmd_error_flag, // Sticky: a command was refused
    input wire clear_status, // Clears sticky flags and latched faults
    input wire start_request, // Start condition level
    input wire vin_ov_fault, // Input overvoltage fault level
    input wire [10:0] vin_meas, // Input voltage in 0.5 V steps
    input wire [10:0] iin_meas, // Input current in 0.5 A steps
    input wire [15:0] vout_meas, // Output voltage in power-good units
    output reg output_enable, // Power stage may switch
    output reg power_good, // Output voltage valid
    output reg uv_warn, // Input undervoltage warning
    output reg oc_warn // Input overcurrent warning
);
    // One-hot states of the output control sequence.
    localparam [4:0] ST_OFF = 5'h01;
    localparam [4:0] ST_DELAY = 5'h02;
    localparam [4:0] ST_ON = 5'h04;
    localparam [4:0] ST_HOLD = 5'h08;
    localparam [4:0] ST_LATCH = 5'h10;

    // Stored command words, loaded with their defaults on reset.
    reg [7:0] ov_reaction_reg;
    reg [15:0] uv_warn_reg;
    reg [15:0] oc_warn_reg;
    reg [15:0] pg_assert_reg;
    reg [15:0] pg_negate_reg;
    reg [15:0] turn_on_delay_time_reg;
    reg [4:0] state_reg;
    reg [4:0] state_next;
    reg [15:0] ms_count_reg;
    reg [10:0] delay_left_reg;

    wire uv_ok;
    wire oc_ok;
    wire ton_ok;
    wire pg_ok;
    wire [1:0] ov_action_code;
    wire [2:0] ov_retry_code;
    wire [2:0] ov_delay_code;
    wire ov_latches;
    wire ov_acts;
    wire ms_tick;
    wire wr_ok;
    wire known;
    reg [15:0] rd_mux;
    wire sel_ov;
    wire sel_uv;
    wire sel_oc;
    wire sel_pg_assert;
    wire sel_pg_negate;
    wire sel_ton;
    wire wr_take;
    wire wr_refuse;
    wire rd_refuse;
    wire refuse;
    wire delay_done;

    linear11_check #(
        .EXP_FIXED(`EXP_HALF),
        .MAN_MIN(`UV_MAN_MIN),
        .MAN_MAX(`UV_MAN_MAX)
    ) uv_check (
        .word(cmd_wdata),
        .ok(uv_ok)
    );

    linear11_check #(
        .EXP_FIXED(`EXP_HALF),
        .MAN_MIN(`OC_MAN_MIN),
        .MAN_MAX(`OC_MAN_MAX)
    ) oc_check (
        .word(cmd_wdata),
        .ok(oc_ok)
    );

    linear11_check #(
        .EXP_FIXED(`EXP_UNIT),
        .MAN_MIN(`TON_MAN_MIN),
        .MAN_MAX(`TON_MAN_MAX)
    ) ton_check (
        .word(cmd_wdata),
        .ok(ton_ok)
    );

    assign pg_ok = (cmd_wdata >= `PG_MIN) && (cmd_wdata <= `PG_MAX);

    assign ov_action_code = ov_reaction_reg[`OV_ACTION_MSB:`OV_ACTION_LSB];
    assign ov_retry_code = ov_reaction_reg[`OV_RETRY_MSB:`OV_RETRY_LSB];
    assign ov_delay_code = ov_reaction_reg[`OV_DELAY_MSB:`OV_DELAY_LSB];
    // Action 00 leaves the output alone whatever retry and delay say.
    assign ov_acts = vin_ov_fault && (ov_action_code != `OV_ACT_IGNORE);
    // Only action 11 with a nonzero retry or delay recovers on its own.
    assign ov_latches = !((ov_action_code == `OV_ACT_HOLD)
        && ((ov_retry_code != 3'h0) || (ov_delay_code != 3'h0)));

    // The millisecond prescaler only runs while the turn-on delay is counting.
    assign ms_tick = (ms_count_reg == CYCLES_PER_MS[15:0] - 16'h0001);

    assign delay_done = (delay_left_reg == 11'h000);

    always @* begin
        case (cmd_code)
            `CMD_OV_REACTION: rd_mux = {8'h00, ov_reaction_reg};
            `CMD_UV_WARN: rd_mux = uv_warn_reg;
            `CMD_OC_WARN: rd_mux = oc_warn_reg;
            `CMD_PG_ASSERT: rd_mux = pg_assert_reg;
            `CMD_PG_NEGATE: rd_mux = pg_negate_reg;
            `CMD_TURN_ON_DELAY_TIME: rd_mux = turn_on_delay_time_reg;
            default: rd_mux = 16'h0000;
        endcase
    end

    // One select per command code keeps the store, read and refusal paths in step.
    assign sel_ov = (cmd_code == `CMD_OV_REACTION);
    assign sel_uv = (cmd_code == `CMD_UV_WARN);
    assign sel_oc = (cmd_code == `CMD_OC_WARN);
    assign sel_pg_assert = (cmd_code == `CMD_PG_ASSERT);
    assign sel_pg_negate = (cmd_code == `CMD_PG_NEGATE);
    assign sel_ton = (cmd_code == `CMD_TURN_ON_DELAY_TIME);

    assign known = sel_ov || sel_uv || sel_oc || sel_pg_assert || sel_pg_negate || sel_ton;

    assign wr_ok = sel_ov
        || (sel_uv && uv_ok)
        || (sel_oc && oc_ok)
        || (sel_pg_assert && pg_ok)
        || (sel_pg_negate && pg_ok)
        || (sel_ton && ton_ok);

    // Writes are judged on the word as offered; reads only need a known code.
    assign wr_take = cmd_valid && cmd_write && wr_ok;
    assign wr_refuse = cmd_valid && cmd_write && !wr_ok;
    assign rd_refuse = cmd_valid && !cmd_write && !known;
    assign refuse = wr_refuse || rd_refuse;

    // Register stores; a refused write leaves the stored value untouched.
    always @(posedge sys_clk) begin
        if (rst) begin
            ov_reaction_reg <= `RST_OV_REACTION;
            uv_warn_reg <= `RST_UV_WARN;
            oc_warn_reg <= `RST_OC_WARN;
            pg_assert_reg <= `RST_PG_ASSERT;
            pg_negate_reg <= `RST_PG_NEGATE;
            turn_on_delay_time_reg <= `RST_TURN_ON_DELAY_TIME;
        end else if (wr_take) begin
            case (cmd_code)
                `CMD_OV_REACTION: ov_reaction_reg <= cmd_wdata[7:0];
                `CMD_UV_WARN: uv_warn_reg <= cmd_wdata;
                `CMD_OC_WARN: oc_warn_reg <= cmd_wdata;
                `CMD_PG_ASSERT: pg_assert_reg <= cmd_wdata;
                `CMD_PG_NEGATE: pg_negate_reg <= cmd_wdata;
                `CMD_TURN_ON_DELAY_TIME: turn_on_delay_time_reg <= cmd_wdata;
                default: ov_reaction_reg <= ov_reaction_reg;
            endcase
        end
    end

    // Answer path: one cycle after every request.
    always @(posedge sys_clk) begin
        if (rst) begin
            rsp_valid <= 1'b0;
            rsp_reject <= 1'b0;
            rsp_rdata <= 16'h0000;
            cmd_error_flag <= 1'b0;
        end else begin
            rsp_valid <= cmd_valid;
            if (cmd_valid) begin
                rsp_reject <= refuse;
                rsp_rdata <= cmd_write ? 16'h0000 : rd_mux;
            end else begin
                rsp_reject <= 1'b0;
                rsp_rdata <= 16'h0000;
            end
            // A refusal in the clearing cycle still sets the flag.
            if (refuse) begin
                cmd_error_flag <= 1'b1;
            end else if (clear_status) begin
                cmd_error_flag <= 1'b0;
            end
        end
    end

    // Output control sequence.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF: begin
                if (start_request) begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY: begin
                if (!start_request) begin
                    state_next = ST_OFF;
                end else if (ov_acts) begin
                    state_next = ov_latches ? ST_LATCH : ST_HOLD;
                end else if (delay_done) begin
                    state_next = ST_ON;
                end
            end
            ST_ON: begin
                if (!start_request) begin
                    state_next = ST_OFF;
                end else if (ov_acts) begin
                    state_next = ov_latches ? ST_LATCH : ST_HOLD;
                end
            end
            // Recovery skips the turn-on delay, even when the fault arrived while still in ST_DELAY.
            ST_HOLD: begin
                if (!start_request) begin
                    state_next = ST_OFF;
                end else if (!vin_ov_fault) begin
                    state_next = ST_ON;
                end
            end
            // Leaving the latch needs a clear and a quiet input; start must then be seen again.
            ST_LATCH: begin
                if (clear_status && !vin_ov_fault) begin
                    state_next = ST_OFF;
                end
            end
            default: state_next = ST_OFF;
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= ST_OFF;
            ms_count_reg <= 16'h0000;
            delay_left_reg <= 11'h000;
            output_enable <= 1'b0;
        end else begin
            state_reg <= state_next;
            // Enable follows the next state so that it rises on the edge entering ON.
            output_enable <= (state_next == ST_ON);
            if (state_reg != ST_DELAY) begin
                ms_count_reg <= 16'h0000;
                delay_left_reg <= turn_on_delay_time_reg[`L11_MAN_MSB:`L11_MAN_LSB];
            end else if (ms_tick) begin
                ms_count_reg <= 16'h0000;
                if (delay_left_reg != 11'h000) begin
                    delay_left_reg <= delay_left_reg - 11'h001;
                end
            end else begin
                ms_count_reg <= ms_count_reg + 16'h0001;
            end
        end
    end

    // Warnings and power good from the measurements.
    always @(posedge sys_clk) begin
        if (rst) begin
            uv_warn <= 1'b0;
            oc_warn <= 1'b0;
            power_good <= 1'b0;
        end else begin
            // Both warning exponents are fixed, so the mantissas compare directly.
            uv_warn <= (vin_meas < uv_warn_reg[`L11_MAN_MSB:`L11_MAN_LSB]);
            oc_warn <= (iin_meas > oc_warn_reg[`L11_MAN_MSB:`L11_MAN_LSB]);
            // Clearing wins, so with a negate level above the assert level power good stays low until the output exceeds the negate level.
            if (!output_enable || (vout_meas <= pg_negate_reg)) begin
                power_good <= 1'b0;
            end else if (vout_meas >= pg_assert_reg) begin
                power_good <= 1'b1;
            end
        end
    end
endmodule // pmbus_input_limit_pgood_regs

// [pmbus_limit_monitor.sv]
// Port-level assertions for the input limit and power-good registers.
`timescale 1ns/1ns
module pmbus_limit_monitor (
    input wire sys_clk, // Clock
    input wire rst, // Reset
    input wire cmd_valid, // Request
    input wire cmd_write, // Write
    input wire [7:0] cmd_code, // Code
    input wire [15:0] cmd_wdata, // Data
    input wire rsp_valid, // Answer
    input wire rsp_reject, // Refusal
    input wire cmd_error_flag, // Sticky
    input wire start_request, // Start
    input wire output_enable, // Enable
    input wire power_good // Good
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    wire is_wr = cmd_valid && cmd_write;
    chk_rsp_next: assert property (cmd_valid |=> rsp_valid)
        else $error("no answer after a request");
    chk_rsp_idle: assert property (!cmd_valid |=> !rsp_valid)
        else $error("answer without a request");
    chk_unknown_code: assert property (cmd_valid && !(cmd_code inside
        {8'h56, 8'h58, 8'h5D, 8'h5E, 8'h5F, 8'h60}) |=> rsp_reject)
        else $error("unknown code not refused");
    chk_uv_exponent: assert property (is_wr && cmd_code == 8'h58
        && cmd_wdata[15:11] != 5'h1F |=> rsp_valid && rsp_reject)
        else $error("bad exponent taken");
    chk_oc_range: assert property (is_wr && cmd_code == 8'h5D
        && cmd_wdata[10:0] > 11'h0FE |=> rsp_reject)
        else $error("overcurrent limit out of range taken");
    chk_ton_range: assert property (is_wr && cmd_code == 8'h60
        && cmd_wdata[10:0] > 11'h07F |=> rsp_reject)
        else $error("delay out of range taken");
    chk_pg_range: assert property (is_wr && cmd_code[7:1] == 7'h2F
        && (cmd_wdata < 16'h007B || cmd_wdata > 16'h1C00) |=> rsp_reject)
        else $error("power-good level out of range taken");
    chk_flag_set: assert property (rsp_valid && rsp_reject
        |-> ##[0:1] cmd_error_flag)
        else $error("refusal not flagged");
    chk_stop_off: assert property (!start_request [*2] |=> !output_enable)
        else $error("output on without start");
    chk_pg_needs_on: assert property (!output_enable [*2] |=> !power_good)
        else $error("power good while output off");
endmodule // pmbus_limit_monitor

bind pmbus_input_limit_pgood_regs pmbus_limit_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
    .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_reject(rsp_reject),
    .cmd_error_flag(cmd_error_flag), .start_request(start_request),
    .output_enable(output_enable), .power_good(power_good));

// [pmbus_host_model.sv]
// Command host model that issues one request and returns the answer.
`timescale 1ns/1ns
module pmbus_host_model (
    input wire sys_clk, // Clock
    output reg cmd_valid, // Request
    output reg cmd_write, // Write
    output reg [7:0] cmd_code, // Code
    output reg [15:0] cmd_wdata, // Data
    input wire rsp_valid, // Answer
    input wire rsp_reject, // Refusal
    input wire [15:0] rsp_rdata // Read data
);
    initial begin
        cmd_valid = 1'b0;
        cmd_write = 1'b0;
        cmd_code = 8'h00;
        cmd_wdata = 16'h0000;
    end
    // Data is inverted once released so that a stale word is never read as valid.
    task xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
              output logic v, output logic r, output logic [15:0] q);
        begin
            @(negedge sys_clk);
            cmd_valid = 1'b1;
            cmd_write = w;
            cmd_code = c;
            cmd_wdata = d;
            @(negedge sys_clk);
            cmd_valid = 1'b0;
            cmd_wdata = ~d;
            v = rsp_valid;
            r = rsp_reject;
            q = rsp_rdata;
        end
    endtask
endmodule // pmbus_host_model

// [pmbus_input_limit_pgood_regs_test.sv]
// Self-checking bench for the input limit and power-good registers.
`timescale 1ns/1ns
module pmbus_input_limit_pgood_regs_test;
    reg sys_clk, rst, clear_status, start_request, vin_ov_fault;
    reg [10:0] vin_meas, iin_meas;
    reg [15:0] vout_meas;
    wire cmd_valid, cmd_write, rsp_valid, rsp_reject, cmd_error_flag;
    wire output_enable, power_good, uv_warn, oc_warn;
    wire [7:0] cmd_code;
    wire [15:0] cmd_wdata, rsp_rdata;
    integer error_cnt = 0;
    integer checks_done = 0;
    logic v, r;
    logic [15:0] q;
    logic [7:0] keep_on [4] = '{8'h00, 8'h16, 8'h22, 8'h36};
    logic [7:0] resume [3] = '{8'hD6, 8'hE2, 8'hF6};
    pmbus_input_limit_pgood_regs #(.CYCLES_PER_MS(4)) u_dut (.sys_clk(sys_clk), .rst(rst),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_reject(rsp_reject),
        .rsp_rdata(rsp_rdata), .cmd_error_flag(cmd_error_flag),
        .clear_status(clear_status), .start_request(start_request),
        .vin_ov_fault(vin_ov_fault), .vin_meas(vin_meas), .iin_meas(iin_meas),
        .vout_meas(vout_meas), .output_enable(output_enable), .power_good(power_good),
        .uv_warn(uv_warn), .oc_warn(oc_warn));
    pmbus_host_model u_host (.sys_clk(sys_clk), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
        .rsp_valid(rsp_valid), .rsp_reject(rsp_reject), .rsp_rdata(rsp_rdata));
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task stop_test;
        begin
            if (error_cnt == 0 && checks_done > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %s expected %h seen %h", n, e, g);
            end
        end
    endtask
    task fchk(input string n, input logic e, input logic g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("wrong value %s expected %b seen %b", n, e, g);
            end
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task cmd(input logic w, input logic [7:0] c, input logic [15:0] d, input logic er,
             input logic [15:0] eq);
        begin
            u_host.xfer(w, c, d, v, r, q);
            fchk("rsp_valid", 1'b1, v);
            fchk("rsp_reject", er, r);
            if (!w)
                chk("rsp_rdata", eq, q);
        end
    endtask
    task wr(input logic [7:0] c, input logic [15:0] d, input logic er, input logic [15:0] a);
        begin
            cmd(1'b1, c, d, er, 16'h0000);
            cmd(1'b0, c, 16'h0000, 1'b0, a);
        end
    endtask
    task t_defaults;
        begin
            cmd(1'b0, 8'h56, 16'h0000, 1'b0, 16'h00B8);
            cmd(1'b0, 8'h58, 16'h0000, 1'b0, 16'hF812);
            cmd(1'b0, 8'h5D, 16'h0000, 1'b0, 16'hF80A);
            cmd(1'b0, 8'h5E, 16'h0000, 1'b0, 16'h0114);
            cmd(1'b0, 8'h5F, 16'h0000, 1'b0, 16'h0105);
            cmd(1'b0, 8'h60, 16'h0000, 1'b0, 16'h0000);
            fchk("cmd_error_flag", 1'b0, cmd_error_flag);
        end
    endtask
    task t_regs;
        begin
            wr(8'h56, 16'hA5C3, 1'b0, 16'h00C3);
            wr(8'h58, 16'hF802, 1'b0, 16'hF802);
            wr(8'h58, 16'hF8A0, 1'b0, 16'hF8A0);
            wr(8'h58, 16'hF8A1, 1'b1, 16'hF8A0);
            wr(8'h58, 16'hF801, 1'b1, 16'hF8A0);
            wr(8'h58, 16'h0812, 1'b1, 16'hF8A0);
            wr(8'h5D, 16'hF800, 1'b0, 16'hF800);
            wr(8'h5D, 16'hF8FE, 1'b0, 16'hF8FE);
            wr(8'h5D, 16'hF8FF, 1'b1, 16'hF8FE);
            wr(8'h5D, 16'hFFFF, 1'b1, 16'hF8FE);
            wr(8'h60, 16'h007F, 1'b0, 16'h007F);
            wr(8'h60, 16'h0080, 1'b1, 16'h007F);
            wr(8'h60, 16'hF805, 1'b1, 16'h007F);
            wr(8'h5E, 16'h1C00, 1'b0, 16'h1C00);
            wr(8'h5E, 16'h1C01, 1'b1, 16'h1C00);
            wr(8'h5F, 16'h007B, 1'b0, 16'h007B);
            wr(8'h5F, 16'h007A, 1'b1, 16'h007B);
            cmd(1'b1, 8'h57, 16'h0001, 1'b1, 16'h0000);
            cmd(1'b0, 8'h57, 16'h0000, 1'b1, 16'h0000);
            fchk("cmd_error_flag", 1'b1, cmd_error_flag);
            clear_status = 1'b1;
            cyc(1);
            clear_status = 1'b0;
            cyc(1);
            fchk("cmd_error_flag", 1'b0, cmd_error_flag);
        end
    endtask
    task ov_case(input logic [7:0] b, input logic ign, input logic rec);
        begin
            cmd(1'b1, 8'h56, {8'h00, b}, 1'b0, 16'h0000);
            start_request = 1'b1;
            cyc(4);
            fchk("output_enable", 1'b1, output_enable);
            vin_ov_fault = 1'b1;
            cyc(3);
            fchk("output_enable", ign, output_enable);
            vin_ov_fault = 1'b0;
            cyc(3);
            fchk("output_enable", ign | rec, output_enable);
            clear_status = 1'b1;
            cyc(1);
            clear_status = 1'b0;
            cyc(4);
            fchk("output_enable", 1'b1, output_enable);
            start_request = 1'b0;
            cyc(3);
        end
    endtask
    task t_ov;
        begin
            wr(8'h60, 16'h0000, 1'b0, 16'h0000);
            ov_case(8'hB8, 1'b0, 1'b0);
            ov_case(8'hC0, 1'b0, 1'b0);
            ov_case(8'h78, 1'b0, 1'b0);
            for (int i = 0; i < 4; i++)
                ov_case(keep_on[i], 1'b1, 1'b0);
            for (int i = 0; i < 3; i++)
                ov_case(resume[i], 1'b0, 1'b1);
        end
    endtask
    task t_ton;
        begin
            wr(8'h60, 16'h0003, 1'b0, 16'h0003);
            start_request = 1'b1;
            cyc(12);
            fchk("output_enable", 1'b0, output_enable);
            cyc(4);
            fchk("output_enable", 1'b1, output_enable);
        end
    endtask
    task t_warn_pg;
        begin
            vin_meas = 11'h09F;
            iin_meas = 11'h0FF;
            vout_meas = 16'h1C00;
            cyc(3);
            fchk("uv_warn", 1'b1, uv_warn);
            fchk("oc_warn", 1'b1, oc_warn);
            fchk("power_good", 1'b1, power_good);
            vin_meas = 11'h0A0;
            iin_meas = 11'h0FE;
            vout_meas = 16'h007C;
            cyc(3);
            fchk("uv_warn", 1'b0, uv_warn);
            fchk("oc_warn", 1'b0, oc_warn);
            fchk("power_good", 1'b1, power_good);
            vout_meas = 16'h007B;
            cyc(3);
            fchk("power_good", 1'b0, power_good);
            start_request = 1'b0;
            cyc(3);
        end
    endtask
    initial begin
        #100000;
        error_cnt = error_cnt + 1;
        stop_test;
    end
    initial begin
        rst = 1'b1;
        {clear_status, start_request, vin_ov_fault} = 3'h0;
        vin_meas = 11'h0C8;
        iin_meas = 11'h000;
        vout_meas = 16'h0000;
        repeat (16) @(negedge sys_clk);
        rst = 1'b0;
        t_defaults;
        t_regs;
        t_ov;
        t_ton;
        t_warn_pg;
        stop_test;
    end
endmodule // pmbus_input_limit_pgood_regs_test
